// *** ccrb_pkg.sv ***
// constants and types shared by the charger control register bank
`default_nettype none
package ccrb_pkg;

  // ************************************************************
  // register offsets and values after reset
  // ************************************************************
  localparam logic [7:0] CCRB_ADDR_PRIMARY = 8'h16;
  localparam logic [7:0] CCRB_ADDR_CONVERTER = 8'h17;
  localparam logic [7:0] CCRB_ADDR_SWITCH = 8'h18;
  localparam logic [7:0] CCRB_RST_PRIMARY = 8'hA1;
  localparam logic [7:0] CCRB_RST_CONVERTER = 8'h4F;
  localparam logic [7:0] CCRB_RST_SWITCH = 8'h04;
  localparam logic [7:0] CCRB_READ_UNMAPPED = 8'h00;

  // ************************************************************
  // field positions, charge_control_primary
  // ************************************************************
  localparam int CCRB_BIT_AUTO_BLEED = 7;
  localparam int CCRB_BIT_BAT_PULLDOWN = 6;
  localparam int CCRB_BIT_CHARGE_EN = 5;
  localparam int CCRB_BIT_HIZ = 4;
  localparam int CCRB_BIT_MID_PULLDOWN = 3;
  localparam int CCRB_BIT_KICK = 2;
  localparam int CCRB_WD_SEL_HI = 1;
  localparam int CCRB_WD_SEL_LO = 0;

  // ************************************************************
  // field positions, converter_protection_control
  // ************************************************************
  localparam int CCRB_BIT_RESTORE = 7;
  localparam int CCRB_BIT_THERMAL = 6;
  localparam int CCRB_DITHER_HI = 5;
  localparam int CCRB_DITHER_LO = 4;
  localparam int CCRB_DRIVE_HI = 3;
  localparam int CCRB_DRIVE_LO = 2;
  localparam int CCRB_BIT_BAT_DRIVE = 1;
  localparam int CCRB_BIT_OVP_SEL = 0;

  // ************************************************************
  // field positions, boost_switch_action_control
  // ************************************************************
  localparam int CCRB_BIT_RESERVED = 7;
  localparam int CCRB_BIT_REV_BOOST = 6;
  localparam int CCRB_BIT_BOOST_PS_DIS = 5;
  localparam int CCRB_BIT_BUCK_PS_DIS = 4;
  localparam int CCRB_BIT_ADAPTER_GATE = 3;
  localparam int CCRB_BIT_ACTION_DELAY = 2;
  localparam int CCRB_ACTION_HI = 1;
  localparam int CCRB_ACTION_LO = 0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CCRB_CLK_HZ = 64'd10_000_000;
  localparam longint CCRB_WD_BASE_S = 64'd40;
  localparam logic [31:0] CCRB_WD_BASE_CYCLES = 32'(CCRB_WD_BASE_S * CCRB_CLK_HZ);
  localparam longint CCRB_DLY_SHORT_MS = 64'd24;
  localparam logic [31:0] CCRB_DLY_SHORT_CYCLES = 32'(CCRB_DLY_SHORT_MS * CCRB_CLK_HZ / 64'd1000);
  localparam longint CCRB_DLY_LONG_S = 64'd12;
  localparam logic [31:0] CCRB_DLY_LONG_CYCLES = 32'(CCRB_DLY_LONG_S * CCRB_CLK_HZ);

  // ************************************************************
  // modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    CCRB_SW_IDLE = 2'b00,
    CCRB_SW_SHUTDOWN = 2'b01,
    CCRB_SW_ULTRA_LOW = 2'b10,
    CCRB_SW_POWER_CYCLE = 2'b11
  } ccrb_sw_mode_t;

  typedef enum logic [1:0] {
    CCRB_ACT_IDLE = 2'b00,
    CCRB_ACT_DELAY = 2'b01,
    CCRB_ACT_WAIT_ADAPTER = 2'b10,
    CCRB_ACT_DONE = 2'b11
  } ccrb_act_state_t;

endpackage
`default_nettype wire

// *** ccrb_watchdog.sv ***
// host timeout watchdog of the charger control register bank
`default_nettype none
module ccrb_watchdog #(
  parameter logic [31:0] BASE_CYCLES = 32'h17D7_8400
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] period_sel,
  input wire logic restart,
  // event
  output logic expire
);

  logic [31:0] count_r;
  logic [31:0] limit;

  // ************************************************************
  // period select
  // ************************************************************
  always_comb begin
    case (period_sel)
      2'b01: limit = BASE_CYCLES;
      2'b10: limit = BASE_CYCLES << 1;
      2'b11: limit = BASE_CYCLES << 2;
      default: limit = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // counter; a disabled watchdog holds at zero
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= 32'h0000_0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart || period_sel == 2'b00) begin // [R7]
        count_r <= 32'h0000_0000;
      end else if (count_r >= limit - 32'h0000_0001) begin // [R8]
        count_r <= 32'h0000_0000;
        expire <= 1'b1; // [R21]
      end else begin
        count_r <= count_r + 32'h0000_0001;
      end
    end
  end

endmodule
`default_nettype wire

// *** ccrb_top.sv ***
// charger control register bank: three host registers and their timers
// Notes on behaviour
// [R1] primary charge control register at 0x16, reset 0xA1.
// [R2] bit 7 bleeds battery while overvoltage is seen; 0 applies no bleed.
// [R3] bit 6 forces battery pulldown; cleared by restore and watchdog expiry.
// [R4] bit 5 enables charging; back to 1 on restore and expiry.
// [R5] bit 4 input high impedance; cleared on adapter plug-in, restore, expiry.
// [R6] bit 3 forces mid node pulldown; cleared by restore and expiry.
// [R7] host writes 1 to bit 2; timer restarts and bit clears itself.
// [R8] bits 1:0 watchdog period: off, 40 s, 80 s, 160 s.
// [R9] converter protection register at 0x17, reset 0x4F.
// [R10] bit 7 restores all defaults and timer, then clears itself.
// [R11] bit 6 thermal limit: 0 is 60 C, 1 is 120 C.
// [R12] bits 5:4 frequency dither level, off then levels one to three.
// [R13] bits 3:2 switch drive level, 11 strongest, lower values weaker.
// [R14] bit 1 battery switch drive level, 1 full, 0 reduced.
// [R15] bit 0 input overvoltage threshold: 0 is 6.3 V, 1 is 18.5 V.
// [R16] switch action register at 0x18, reset 0x04, bit 7 reads zero.
// [R17] bits 1:0 force idle, shutdown, ultra low power or power cycle.
// [R18] bit 2 delays the switch action: 0 is 24 ms, 1 is 12 s.
// [R19] bit 3 lets power cycle start with adapter present, else after removal.
// [R20] bit 6 reverse boost, bits 5 and 4 disable pulse skipping.
// [R21] unrefreshed enabled watchdog restores every watchdog-resettable field.
// [R22] self-clearing command bits read back zero once acted on.
`default_nettype none
module ccrb_top
  import ccrb_pkg::*;
#(
  parameter logic [31:0] WD_BASE_CYCLES = ccrb_pkg::CCRB_WD_BASE_CYCLES,
  parameter logic [31:0] DLY_SHORT_CYCLES = ccrb_pkg::CCRB_DLY_SHORT_CYCLES,
  parameter logic [31:0] DLY_LONG_CYCLES = ccrb_pkg::CCRB_DLY_LONG_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // register port from the serial bus engine
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // analog status
  input wire logic ADAPTER_PRESENT,
  input wire logic BAT_OVP_DETECT,
  // primary controls
  output logic BAT_BLEED_ON,
  output logic CHARGE_ENABLE,
  output logic INPUT_HIZ,
  output logic MID_NODE_PULLDOWN,
  output logic WD_EXPIRED,
  // converter controls
  output logic THERMAL_LIMIT_SELECT,
  output logic [1:0] DITHER_LEVEL,
  output logic [1:0] SWITCH_DRIVE_LEVEL,
  output logic BATTERY_SWITCH_DRIVE_LEVEL,
  output logic INPUT_OVERVOLTAGE_SELECT,
  // boost and battery switch controls
  output logic REVERSE_BOOST_ENABLE,
  output logic BOOST_PULSE_SKIP_DISABLE,
  output logic BUCK_PULSE_SKIP_DISABLE,
  output logic [1:0] SWITCH_ACTION_MODE
);

  logic [7:0] primary_r;
  logic [7:0] converter_r;
  logic [7:0] switch_r;
  logic adapter_prev_r;
  logic adapter_rise;
  logic wr_primary;
  logic wr_converter;
  logic wr_switch;
  logic restore;
  logic kick;
  logic wd_expire;
  logic bleed_r;
  logic expired_r;
  ccrb_act_state_t act_state_r;
  ccrb_act_state_t act_state_nxt;
  logic [31:0] delay_r;
  logic [31:0] delay_nxt;
  ccrb_sw_mode_t mode_r;
  ccrb_sw_mode_t mode_nxt;
  logic [1:0] action;
  logic start_action;

  // ************************************************************
  // write decode
  // ************************************************************
  always_comb begin
    wr_primary = 1'b0;
    wr_converter = 1'b0;
    wr_switch = 1'b0;
    if (REG_WR && REG_ADDR == CCRB_ADDR_PRIMARY) begin // [R1]
      wr_primary = 1'b1;
    end else if (REG_WR && REG_ADDR == CCRB_ADDR_CONVERTER) begin // [R9]
      wr_converter = 1'b1;
    end else if (REG_WR && REG_ADDR == CCRB_ADDR_SWITCH) begin // [R16]
      wr_switch = 1'b1;
    end
  end

  // command bits are acted on the cycle after they are written
  assign restore = converter_r[CCRB_BIT_RESTORE];
  assign kick = primary_r[CCRB_BIT_KICK];
  assign adapter_rise = ADAPTER_PRESENT && !adapter_prev_r;
  assign action = switch_r[CCRB_ACTION_HI:CCRB_ACTION_LO];
  assign start_action = wr_switch && REG_WDATA[CCRB_ACTION_HI:CCRB_ACTION_LO] != 2'b00;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      // seeded from the pin, so an adapter already present at reset is no plug-in edge
      adapter_prev_r <= ADAPTER_PRESENT;
    end else begin
      adapter_prev_r <= ADAPTER_PRESENT;
    end
  end

  // ************************************************************
  // watchdog
  // ************************************************************
  ccrb_watchdog #(
    .BASE_CYCLES(WD_BASE_CYCLES)
  ) u_watchdog (
    .clk(MCLK),
    .rst_n(RESET_N),
    .period_sel(primary_r[CCRB_WD_SEL_HI:CCRB_WD_SEL_LO]), // [R8]
    .restart(kick || restore), // [R7] [R10]
    .expire(wd_expire)
  );

  // ************************************************************
  // charge_control_primary
  // ************************************************************
  // a host write in the same cycle as a hardware clear wins
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      primary_r <= CCRB_RST_PRIMARY; // [R1]
    end else begin
      if (restore) begin
        primary_r <= CCRB_RST_PRIMARY; // [R10]
      end else begin
        if (wd_expire) begin // [R21]
          primary_r[CCRB_BIT_BAT_PULLDOWN] <= 1'b0; // [R3]
          primary_r[CCRB_BIT_CHARGE_EN] <= 1'b1; // [R4]
          primary_r[CCRB_BIT_HIZ] <= 1'b0; // [R5]
          primary_r[CCRB_BIT_MID_PULLDOWN] <= 1'b0; // [R6]
        end
        if (adapter_rise) begin
          primary_r[CCRB_BIT_HIZ] <= 1'b0; // [R5]
        end
        if (kick) begin
          primary_r[CCRB_BIT_KICK] <= 1'b0; // [R7] [R22]
        end
      end
      if (wr_primary) begin
        primary_r <= REG_WDATA;
      end
    end
  end

  // ************************************************************
  // converter_protection_control
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      converter_r <= CCRB_RST_CONVERTER; // [R9]
    end else begin
      if (restore) begin
        converter_r <= CCRB_RST_CONVERTER; // [R10] [R22]
      end
      if (wr_converter) begin
        converter_r <= REG_WDATA; // [R11] [R12] [R13] [R14] [R15]
      end
    end
  end

  // ************************************************************
  // boost_switch_action_control
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      switch_r <= CCRB_RST_SWITCH; // [R16]
    end else begin
      if (restore) begin
        switch_r <= CCRB_RST_SWITCH; // [R10]
      end else if (wd_expire) begin
        switch_r[CCRB_BIT_REV_BOOST] <= 1'b0; // [R21]
      end
      if (wr_switch) begin
        switch_r <= {1'b0, REG_WDATA[CCRB_BIT_REV_BOOST:0]}; // [R16] [R20]
      end
    end
  end

  // ************************************************************
  // battery switch action sequencer
  // ************************************************************
  // the delay starts when a non-idle action is written; rewriting restarts it
  always_comb begin
    act_state_nxt = act_state_r;
    delay_nxt = delay_r;
    mode_nxt = mode_r;
    if (start_action) begin
      act_state_nxt = CCRB_ACT_DELAY;
      if (REG_WDATA[CCRB_BIT_ACTION_DELAY]) begin // [R18]
        delay_nxt = DLY_LONG_CYCLES - 32'h0000_0001;
      end else begin
        delay_nxt = DLY_SHORT_CYCLES - 32'h0000_0001;
      end
    end else if (action == 2'b00) begin
      act_state_nxt = CCRB_ACT_IDLE;
      delay_nxt = 32'h0000_0000;
      mode_nxt = CCRB_SW_IDLE; // [R17]
    end else begin
      case (act_state_r)
        CCRB_ACT_IDLE: begin
          act_state_nxt = CCRB_ACT_IDLE;
        end
        CCRB_ACT_DELAY: begin
          if (delay_r != 32'h0000_0000) begin
            delay_nxt = delay_r - 32'h0000_0001; // [R18]
          end else if (action == CCRB_SW_POWER_CYCLE && !switch_r[CCRB_BIT_ADAPTER_GATE]
                       && ADAPTER_PRESENT) begin
            act_state_nxt = CCRB_ACT_WAIT_ADAPTER; // [R19]
          end else begin
            act_state_nxt = CCRB_ACT_DONE;
            mode_nxt = ccrb_sw_mode_t'(action); // [R17]
          end
        end
        CCRB_ACT_WAIT_ADAPTER: begin
          if (switch_r[CCRB_BIT_ADAPTER_GATE] || !ADAPTER_PRESENT) begin // [R19]
            act_state_nxt = CCRB_ACT_DONE;
            mode_nxt = ccrb_sw_mode_t'(action);
          end
        end
        CCRB_ACT_DONE: begin
          act_state_nxt = CCRB_ACT_DONE;
        end
        default: begin
          act_state_nxt = CCRB_ACT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      act_state_r <= CCRB_ACT_IDLE;
      delay_r <= 32'h0000_0000;
      mode_r <= CCRB_SW_IDLE;
    end else begin
      act_state_r <= act_state_nxt;
      delay_r <= delay_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ************************************************************
  // derived outputs
  // ************************************************************
  // the bleed mixes a live status pin, so it gets its own flop
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      bleed_r <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      bleed_r <= primary_r[CCRB_BIT_BAT_PULLDOWN]
                 || (primary_r[CCRB_BIT_AUTO_BLEED] && BAT_OVP_DETECT); // [R2] [R3]
      expired_r <= wd_expire;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      REG_RDATA <= CCRB_READ_UNMAPPED;
    end else if (REG_RD) begin
      if (REG_ADDR == CCRB_ADDR_PRIMARY) begin
        REG_RDATA <= primary_r; // [R22]
      end else if (REG_ADDR == CCRB_ADDR_CONVERTER) begin
        REG_RDATA <= converter_r; // [R22]
      end else if (REG_ADDR == CCRB_ADDR_SWITCH) begin
        REG_RDATA <= {1'b0, switch_r[CCRB_BIT_REV_BOOST:0]}; // [R16]
      end else begin
        REG_RDATA <= CCRB_READ_UNMAPPED;
      end
    end
  end

  assign BAT_BLEED_ON = bleed_r;
  assign CHARGE_ENABLE = primary_r[CCRB_BIT_CHARGE_EN]; // [R4]
  assign INPUT_HIZ = primary_r[CCRB_BIT_HIZ]; // [R5]
  assign MID_NODE_PULLDOWN = primary_r[CCRB_BIT_MID_PULLDOWN]; // [R6]
  assign WD_EXPIRED = expired_r;
  assign THERMAL_LIMIT_SELECT = converter_r[CCRB_BIT_THERMAL]; // [R11]
  assign DITHER_LEVEL = converter_r[CCRB_DITHER_HI:CCRB_DITHER_LO]; // [R12]
  assign SWITCH_DRIVE_LEVEL = converter_r[CCRB_DRIVE_HI:CCRB_DRIVE_LO]; // [R13]
  assign BATTERY_SWITCH_DRIVE_LEVEL = converter_r[CCRB_BIT_BAT_DRIVE]; // [R14]
  assign INPUT_OVERVOLTAGE_SELECT = converter_r[CCRB_BIT_OVP_SEL]; // [R15]
  assign REVERSE_BOOST_ENABLE = switch_r[CCRB_BIT_REV_BOOST]; // [R20]
  assign BOOST_PULSE_SKIP_DISABLE = switch_r[CCRB_BIT_BOOST_PS_DIS]; // [R20]
  assign BUCK_PULSE_SKIP_DISABLE = switch_r[CCRB_BIT_BUCK_PS_DIS]; // [R20]
  assign SWITCH_ACTION_MODE = mode_r;

endmodule
`default_nettype wire

// *** ccrb_checker.sv ***
// port assertions for the charger control register bank
`default_nettype none
module ccrb_checker #(
  parameter logic [31:0] DLY_SHORT_CYCLES = 32'h5
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // controls
  input wire logic WD_EXPIRED,
  input wire logic CHARGE_ENABLE,
  input wire logic INPUT_HIZ,
  input wire logic MID_NODE_PULLDOWN,
  input wire logic THERMAL_LIMIT_SELECT,
  input wire logic [1:0] DITHER_LEVEL,
  input wire logic [1:0] SWITCH_DRIVE_LEVEL,
  input wire logic BATTERY_SWITCH_DRIVE_LEVEL,
  input wire logic INPUT_OVERVOLTAGE_SELECT,
  input wire logic REVERSE_BOOST_ENABLE,
  input wire logic BOOST_PULSE_SKIP_DISABLE,
  input wire logic BUCK_PULSE_SKIP_DISABLE,
  input wire logic [1:0] SWITCH_ACTION_MODE
);
  localparam int SHORT_MAX = DLY_SHORT_CYCLES + 4;
  logic [7:0] wdata_q;
  wire logic [6:0] conv_w = {THERMAL_LIMIT_SELECT, DITHER_LEVEL, SWITCH_DRIVE_LEVEL,
    BATTERY_SWITCH_DRIVE_LEVEL, INPUT_OVERVOLTAGE_SELECT};
  // a field is matched to the byte written one edge earlier
  always_ff @(posedge MCLK) begin
    wdata_q <= REG_WDATA;
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  // ******
  // sequences
  // ******
  sequence restore_req;
    REG_WR && REG_ADDR == 8'h17 && REG_WDATA[7] ##1 !REG_WR;
  endsequence
  sequence at_defaults;
    CHARGE_ENABLE && !INPUT_HIZ && !MID_NODE_PULLDOWN && conv_w == 7'h4F
      && !REVERSE_BOOST_ENABLE && !BOOST_PULSE_SKIP_DISABLE && !BUCK_PULSE_SKIP_DISABLE;
  endsequence
  sequence act_start;
    REG_WR && REG_ADDR == 8'h18 && REG_WDATA[2:0] == 3'h1 && SWITCH_ACTION_MODE == 2'h0;
  endsequence
  // ******
  // assertions
  // ******
  unmapped_read_a: assert property (REG_RD && !(REG_ADDR inside {8'h16, 8'h17, 8'h18})
    |=> REG_RDATA == 8'h00) else $error("unmapped read returned data");
  reserved_bit_a: assert property (REG_RD && REG_ADDR == 8'h18
    |=> !REG_RDATA[7]) else $error("reserved bit read as one");
  read_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  primary_write_a: assert property (REG_WR && REG_ADDR == 8'h16
    |=> {CHARGE_ENABLE, INPUT_HIZ, MID_NODE_PULLDOWN} == wdata_q[5:3])
    else $error("primary write not applied");
  conv_write_a: assert property (REG_WR && REG_ADDR == 8'h17
    |=> conv_w == wdata_q[6:0]) else $error("converter write not applied");
  boost_write_a: assert property (REG_WR && REG_ADDR == 8'h18
    |=> {REVERSE_BOOST_ENABLE, BOOST_PULSE_SKIP_DISABLE, BUCK_PULSE_SKIP_DISABLE}
    == wdata_q[6:4]) else $error("boost write not applied");
  wd_pulse_a: assert property (WD_EXPIRED |=> !WD_EXPIRED)
    else $error("expiry flag longer than one cycle");
  wd_restore_a: assert property (WD_EXPIRED && !$past(REG_WR)
    |-> CHARGE_ENABLE && !INPUT_HIZ && !MID_NODE_PULLDOWN && !REVERSE_BOOST_ENABLE)
    else $error("expiry left fields set");
  restore_all_a: assert property (restore_req |=> at_defaults)
    else $error("restore did not reach defaults");
  action_idle_a: assert property (REG_WR && REG_ADDR == 8'h18 && REG_WDATA[1:0] == 2'h0
    |-> ##2 SWITCH_ACTION_MODE == 2'h0) else $error("idle action not applied");
  action_delay_a: assert property (act_start |=> (SWITCH_ACTION_MODE == 2'h0) [*2]
    ##[1:SHORT_MAX] (SWITCH_ACTION_MODE == 2'h1 || REG_WR))
    else $error("short action delay wrong");
endmodule
bind ccrb_top ccrb_checker #(.DLY_SHORT_CYCLES(DLY_SHORT_CYCLES)) u_checker (.*);
`default_nettype wire

// *** ccrb_host.sv ***
// host processor model on the register port
`default_nettype none
module ccrb_host (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one strobe per byte; released lines show the inverse, never a stale copy
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** ccrb_tb_top.sv ***
// self-checking bench for the charger control register bank
`default_nettype none
module ccrb_tb_top;
  import ccrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // short counts keep watchdog and switch delays inside a brief run
  localparam logic [31:0] WD_N = 32'h32;
  localparam logic [31:0] SHORT_N = 32'h5;
  localparam logic [31:0] LONG_N = 32'h14;
  logic MCLK, RESET_N, ADAPTER_PRESENT, BAT_OVP_DETECT;
  wire logic [7:0] REG_ADDR, REG_WDATA;
  wire logic REG_WR, REG_RD;
  logic [7:0] REG_RDATA;
  logic BAT_BLEED_ON, CHARGE_ENABLE, INPUT_HIZ, MID_NODE_PULLDOWN, WD_EXPIRED;
  logic THERMAL_LIMIT_SELECT, BATTERY_SWITCH_DRIVE_LEVEL, INPUT_OVERVOLTAGE_SELECT;
  logic [1:0] DITHER_LEVEL, SWITCH_DRIVE_LEVEL, SWITCH_ACTION_MODE;
  logic REVERSE_BOOST_ENABLE, BOOST_PULSE_SKIP_DISABLE, BUCK_PULSE_SKIP_DISABLE;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic [7:0] prim_o = {1'b0, BAT_BLEED_ON, CHARGE_ENABLE, INPUT_HIZ, MID_NODE_PULLDOWN,
    3'h0};
  wire logic [7:0] conv_o = {1'b0, THERMAL_LIMIT_SELECT, DITHER_LEVEL, SWITCH_DRIVE_LEVEL,
    BATTERY_SWITCH_DRIVE_LEVEL, INPUT_OVERVOLTAGE_SELECT};
  wire logic [7:0] boost_o = {1'b0, REVERSE_BOOST_ENABLE, BOOST_PULSE_SKIP_DISABLE,
    BUCK_PULSE_SKIP_DISABLE, 2'h0, SWITCH_ACTION_MODE};
  ccrb_top #(.WD_BASE_CYCLES(WD_N), .DLY_SHORT_CYCLES(SHORT_N), .DLY_LONG_CYCLES(LONG_N))
    u_dut (.*);
  ccrb_host u_host (.clk(MCLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));
  // ******
  // helpers
  // ******
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.put(a, d, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.put(a, 8'h00, 1'b0);
    cyc_wait(1);
    chk($sformatf("reg %h", a), e, REG_RDATA);
  endtask
  task automatic wait_mode(input logic [1:0] m, output int n);
    n = 0;
    while (SWITCH_ACTION_MODE !== m && n < 60) begin
      cyc_wait(1);
      n++;
    end
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_reset;
    rdc(CCRB_ADDR_PRIMARY, 8'hA1);
    rdc(CCRB_ADDR_CONVERTER, 8'h4F);
    rdc(CCRB_ADDR_SWITCH, 8'h04);
    rdc(8'h19, 8'h00);
    chk("conv outs", 8'h4F, conv_o);
    chk("boost outs", 8'h00, boost_o);
    chk("prim outs", 8'h20, prim_o);
  endtask
  task automatic t_fields;
    logic [7:0] d;
    wr(CCRB_ADDR_PRIMARY, 8'h78);
    cyc_wait(2);
    chk("prim outs", 8'h78, prim_o);
    wr(CCRB_ADDR_PRIMARY, 8'h80);
    BAT_OVP_DETECT <= 1'b1;
    cyc_wait(3);
    chk("bleed on", 8'h40, prim_o);
    wr(CCRB_ADDR_PRIMARY, 8'h00);
    cyc_wait(3);
    chk("bleed off", 8'h00, prim_o);
    BAT_OVP_DETECT <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, i[0], i[1:0], 2'(3 - i), ~i[0], i[1]};
      wr(CCRB_ADDR_CONVERTER, d);
      cyc_wait(1);
      chk("conv outs", d, conv_o);
      rdc(CCRB_ADDR_CONVERTER, d);
    end
  endtask
  task automatic t_hiz;
    wr(CCRB_ADDR_PRIMARY, 8'h10);
    cyc_wait(2);
    chk("hiz set", 8'h10, prim_o);
    ADAPTER_PRESENT <= 1'b1;
    cyc_wait(3);
    chk("hiz plug", 8'h00, prim_o);
    rdc(CCRB_ADDR_PRIMARY, 8'h00);
    ADAPTER_PRESENT <= 1'b0;
  endtask
  task automatic t_wd;
    int n;
    int lim;
    wr(CCRB_ADDR_SWITCH, 8'h44);
    wr(CCRB_ADDR_PRIMARY, 8'h5D);
    rdc(CCRB_ADDR_PRIMARY, 8'h59);
    for (int p = 1; p < 4; p++) begin
      lim = int'(WD_N) << (p - 1);
      wr(CCRB_ADDR_PRIMARY, 8'h5C | 8'(p));
      n = 0;
      while (WD_EXPIRED !== 1'b1 && n < 300) begin
        cyc_wait(1);
        n++;
      end
      chk("wd period", 8'h01, 8'(n >= lim && n <= lim + 4));
      cyc_wait(1);
      chk("wd restore", 8'h20, prim_o);
      rdc(CCRB_ADDR_PRIMARY, 8'h20 | 8'(p));
    end
    wr(CCRB_ADDR_PRIMARY, 8'h00);
    n = 0;
    repeat (250) begin
      cyc_wait(1);
      n += int'(WD_EXPIRED === 1'b1);
    end
    chk("wd off", 8'h00, 8'(n));
    rdc(CCRB_ADDR_SWITCH, 8'h04);
  endtask
  task automatic t_restore;
    wr(CCRB_ADDR_CONVERTER, 8'h00);
    wr(CCRB_ADDR_PRIMARY, 8'h7A);
    wr(CCRB_ADDR_SWITCH, 8'h78);
    wr(CCRB_ADDR_CONVERTER, 8'h80);
    rdc(CCRB_ADDR_PRIMARY, 8'hA1);
    rdc(CCRB_ADDR_CONVERTER, 8'h4F);
    rdc(CCRB_ADDR_SWITCH, 8'h04);
  endtask
  task automatic t_boost;
    wr(CCRB_ADDR_PRIMARY, 8'h00);
    wr(CCRB_ADDR_SWITCH, 8'hF4);
    cyc_wait(1);
    chk("boost outs", 8'h70, boost_o);
    rdc(CCRB_ADDR_SWITCH, 8'h74);
    wr(8'h19, 8'hFF);
    rdc(8'h19, 8'h00);
    rdc(CCRB_ADDR_CONVERTER, 8'h4F);
  endtask
  task automatic t_action;
    int n;
    int dl;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      d = (k < 3) ? 8'h08 | 8'(k + 1) : 8'h0D;
      dl = d[2] ? int'(LONG_N) : int'(SHORT_N);
      wr(CCRB_ADDR_SWITCH, d);
      wait_mode(d[1:0], n);
      chk("act delay", 8'h01, 8'(n >= dl && n <= dl + 4));
      wr(CCRB_ADDR_SWITCH, 8'h08);
      cyc_wait(1);
      chk("act idle", 8'h00, {6'h00, SWITCH_ACTION_MODE});
    end
    ADAPTER_PRESENT <= 1'b1;
    wr(CCRB_ADDR_SWITCH, 8'h03);
    cyc_wait(30);
    chk("pc held", 8'h00, {6'h00, SWITCH_ACTION_MODE});
    ADAPTER_PRESENT <= 1'b0;
    wait_mode(2'h3, n);
    chk("pc removed", 8'h03, {6'h00, SWITCH_ACTION_MODE});
    wr(CCRB_ADDR_CONVERTER, 8'h80);
    cyc_wait(2);
    chk("restore mode", 8'h00, {6'h00, SWITCH_ACTION_MODE});
  endtask
  // ******
  // clock, reset, sequence
  // ******
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    RESET_N = 1'b0;
    ADAPTER_PRESENT = 1'b0;
    BAT_OVP_DETECT = 1'b0;
    repeat (20) @(posedge MCLK);
    RESET_N <= 1'b1;
    t_reset();
    t_fields();
    t_hiz();
    t_wd();
    t_restore();
    t_boost();
    t_action();
    results();
  end
endmodule
`default_nettype wire
